// ### core/adct_pkg.sv
package adct_pkg;
    localparam int unsigned CLK_PS = 8000;
    localparam int unsigned PS_PER_NS = 1000;
    localparam int unsigned NS_PER_US = 1000;
    localparam int unsigned NS_PER_MS = 1000000;
    localparam int unsigned ROW_W = 12;
    localparam int unsigned COL_W = 8;
    localparam int unsigned ADDR_W = ROW_W + COL_W;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned SYNC_LAT = 2;
    localparam int unsigned INIT_REFS = 8;
    localparam int unsigned REF_ROWS = 4096;
    localparam int unsigned PAGE_GUARD = 64;

    // slower grade figures, which also satisfy the faster grade
    localparam int unsigned T_REF_MS = 64;
    localparam int unsigned T_REFI_NS = T_REF_MS * NS_PER_MS / REF_ROWS;
    localparam int unsigned T_PWR_US = 500;
    localparam int unsigned T_SR_US = 100;
    localparam int unsigned T_RASP_NS = 125000;
    localparam int unsigned T_RP_NS = 50;
    localparam int unsigned T_RAS_NS = 70;
    localparam int unsigned T_RAH_NS = 10;
    localparam int unsigned T_RCD_NS = 20;
    localparam int unsigned T_RAC_NS = 70;
    localparam int unsigned T_CRA_NS = 40;
    localparam int unsigned T_OED_NS = 15;
    localparam int unsigned T_RWL_NS = 20;
    localparam int unsigned T_CP_NS = 10;
    localparam int unsigned T_PC_NS = 45;
    localparam int unsigned T_PRC_NS = 95;
    localparam int unsigned T_CSR_NS = 10;
    localparam int unsigned T_CHR_NS = 15;
    localparam int unsigned T_RPS_NS = 110;
    localparam int unsigned T_CWD_NS = 45;
    localparam int unsigned T_RWD_NS = 95;
    localparam int unsigned T_AWD_NS = 60;
    localparam int unsigned T_CPWD_NS = 65;

    function automatic int unsigned cyc_min(input int unsigned ns);
        int unsigned c;
        c = (ns * PS_PER_NS + CLK_PS - 1) / CLK_PS;
        return (c == 0) ? 1 : c;
    endfunction

    function automatic int unsigned cyc_max(input int unsigned ns);
        int unsigned c;
        c = ns * PS_PER_NS / CLK_PS;
        return (c == 0) ? 1 : c;
    endfunction

    function automatic int unsigned max3(input int unsigned a, b, c);
        int unsigned m;
        m = (a > b) ? a : b;
        return (m > c) ? m : c;
    endfunction

    localparam int unsigned PWR_CYC_DEF = cyc_min(T_PWR_US * NS_PER_US);
    localparam int unsigned SR_CYC_DEF = cyc_min(T_SR_US * NS_PER_US);
    localparam int unsigned RASP_CYC_DEF = cyc_max(T_RASP_NS);
    localparam int unsigned REFI_CYC_DEF = cyc_max(T_REFI_NS);

    localparam logic [7:0] RP_CYC = 8'(cyc_min(T_RP_NS));
    localparam logic [7:0] RAS_MIN_CYC = 8'(cyc_min(T_RAS_NS));
    localparam logic [7:0] RAH_CYC = 8'(cyc_min(T_RAH_NS));
    localparam logic [7:0] RCD_CYC = 8'(cyc_min(T_RCD_NS));
    localparam logic [7:0] COL_WT = (RCD_CYC > RAH_CYC + 8'h01) ? RCD_CYC - RAH_CYC - 8'h01 : 8'h00;
    localparam logic [7:0] RD_CAS_CYC = 8'(cyc_min(T_CRA_NS) + SYNC_LAT);
    localparam logic [7:0] RD_RAS_CYC = 8'(cyc_min(T_RAC_NS) + SYNC_LAT);
    localparam logic [7:0] OED_CYC = 8'(cyc_min(T_OED_NS));
    localparam logic [7:0] RWL_CYC = 8'(cyc_min(T_RWL_NS));
    localparam logic [7:0] CP_CYC = 8'(cyc_min(T_CP_NS));
    localparam logic [7:0] PC_CYC = 8'(cyc_min(T_PC_NS));
    localparam logic [7:0] PRC_CYC = 8'(cyc_min(T_PRC_NS));
    localparam logic [7:0] CSR_CYC = 8'(cyc_min(T_CSR_NS));
    localparam logic [7:0] REF_LOW_CYC = 8'(max3(cyc_min(T_RAS_NS), cyc_min(T_CHR_NS), 1));
    localparam logic [7:0] RPS_CYC = 8'(cyc_min(T_RPS_NS));
    localparam logic [7:0] RWD_CYC = 8'(cyc_min(T_RWD_NS));
    localparam logic [7:0] WE_CAS_CYC =
        8'(max3(cyc_min(T_CWD_NS), cyc_min(T_AWD_NS), cyc_min(T_CPWD_NS)));

    typedef struct packed {
        logic write;
        logic rmw;
        logic [1:0] be;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } adct_req_s;

    typedef struct packed {
        logic ras_n;
        logic high_byte_column_strobe_n;
        logic low_byte_column_strobe_n;
        logic we_n;
        logic oe_n;
        logic [ROW_W-1:0] addr;
    } adct_pins_s;

    localparam adct_pins_s PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 12'h000};

    typedef enum logic [12:0] {
        ST_INIT = 13'h0001,
        ST_IDLE = 13'h0002,
        ST_ROW = 13'h0004,
        ST_COL = 13'h0008,
        ST_ACC = 13'h0010,
        ST_TURN = 13'h0020,
        ST_WR = 13'h0040,
        ST_PAGE = 13'h0080,
        ST_PRE = 13'h0100,
        ST_RCAS = 13'h0200,
        ST_HID = 13'h0400,
        ST_RRAS = 13'h0800,
        ST_SR = 13'h1000
    } adct_state_e;
endpackage

// ### core/adct_sync.sv
`timescale 1ns/1ps
`default_nettype none
module adct_sync
    import adct_pkg::*;
#(
    parameter int unsigned WIDTH = DATA_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (rst) begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end else begin
                meta_q[i] <= d[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    assign q = sync_q;
endmodule // adct_sync
`default_nettype wire

// ### core/adct_tick.sv
`timescale 1ns/1ps
`default_nettype none
module adct_tick
    import adct_pkg::*;
#(
    parameter int unsigned PERIOD = REFI_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    output logic pulse
);
    localparam int unsigned CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_q;
    logic pulse_q;

    // one-cycle enable every PERIOD clocks
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_q <= '0;
            pulse_q <= 1'b0;
        end else begin
            pulse_q <= (cnt_q == LAST);
            cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
        end
    end

    assign pulse = pulse_q;
endmodule // adct_tick
`default_nettype wire

// ### core/adct_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module adct_ctrl
    import adct_pkg::*;
#(
    parameter int unsigned PWR_CYC = PWR_CYC_DEF,
    parameter int unsigned SR_CYC = SR_CYC_DEF,
    parameter int unsigned RASP_CYC = RASP_CYC_DEF,
    parameter int unsigned REFI_CYC = REFI_CYC_DEF
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input wire adct_req_s req,
    output logic req_ack,
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_data,
    input wire logic sr_req,
    output logic sr_active,
    output logic init_done,
    output var adct_pins_s pins,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe,
    input wire logic [DATA_W-1:0] dq_in
);
    localparam int unsigned RL_W = $clog2((SR_CYC > RASP_CYC ? SR_CYC : RASP_CYC) + 1) + 1;
    localparam logic [RL_W-1:0] PAGE_LIM = RL_W'(RASP_CYC - PAGE_GUARD);

    adct_state_e state_q;
    adct_req_s cur_q;
    adct_pins_s pins_q;
    logic [7:0] wt_q;
    logic [7:0] pc_q;
    logic [RL_W-1:0] rl_q;
    logic [3:0] init_left_q;
    logic pwr_done_q, ref_pend_q, sr_mode_q, ack_q, rsp_valid_q, init_done_q, dq_oe_q;
    logic sr_active_q;
    logic [DATA_W-1:0] rsp_data_q;
    logic [DATA_W-1:0] dq_out_q;
    logic [DATA_W-1:0] dq_s;
    logic ref_tick, pwr_tick;
    logic row_hit, page_ok, cur_wr, cas_n;

    ////////////////////////////////////////////////////////////////////////////
    adct_sync #(.WIDTH(DATA_W)) u_dq_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .d(dq_in),
        .q(dq_s)
    );

    adct_tick #(.PERIOD(REFI_CYC)) u_ref_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .pulse(ref_tick)
    );

    adct_tick #(.PERIOD(PWR_CYC)) u_pwr_tick (
        .sys_clk(sys_clk),
        .rst(rst),
        .pulse(pwr_tick)
    );

    assign row_hit = req.addr[ADDR_W-1:COL_W] == cur_q.addr[ADDR_W-1:COL_W];
    assign page_ok = req_valid && row_hit && (rl_q < PAGE_LIM) && !ref_pend_q && !sr_req;
    assign cur_wr = cur_q.write && !cur_q.rmw;
    assign cas_n = pins_q.low_byte_column_strobe_n & pins_q.high_byte_column_strobe_n;

    ////////////////////////////////////////////////////////////////////////////
    // cycles since row strobe fell and since column strobe fell
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rl_q <= '0;
            pc_q <= '0;
        end else begin
            rl_q <= pins_q.ras_n ? '0 : ((&rl_q) ? rl_q : rl_q + 1'b1);
            pc_q <= (state_q == ST_COL) ? '0 : ((&pc_q) ? pc_q : pc_q + 1'b1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk) begin
        logic fin;
        fin = 1'b0;
        if (rst) begin
            state_q <= ST_INIT;
            pins_q <= PINS_IDLE;
            cur_q <= '0;
            wt_q <= '0;
            init_left_q <= 4'(INIT_REFS);
            pwr_done_q <= 1'b0;
            ref_pend_q <= 1'b0;
            sr_mode_q <= 1'b0;
            sr_active_q <= 1'b0;
            ack_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= '0;
            init_done_q <= 1'b0;
            dq_oe_q <= 1'b0;
            dq_out_q <= '0;
        end else begin
            ack_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            if (wt_q != 8'h00) wt_q <= wt_q - 8'h01;
            if (ref_tick) ref_pend_q <= 1'b1;
            if (pwr_tick) pwr_done_q <= 1'b1;
            case (state_q)
                ST_INIT: begin
                    if (pwr_done_q) state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    init_done_q <= (init_left_q == 4'h0);
                    if (init_left_q != 4'h0 || ref_pend_q || (sr_req && init_done_q)) begin
                        pins_q.low_byte_column_strobe_n <= 1'b0;
                        pins_q.high_byte_column_strobe_n <= 1'b0;
                        ref_pend_q <= ref_tick;
                        sr_mode_q <= sr_req && init_done_q;
                        if (init_left_q != 4'h0) init_left_q <= init_left_q - 4'h1;
                        wt_q <= CSR_CYC - 8'h01;
                        state_q <= ST_RCAS;
                    end else if (req_valid && init_done_q) begin
                        cur_q <= req;
                        ack_q <= 1'b1;
                        pins_q.ras_n <= 1'b0;
                        pins_q.addr <= req.addr[ADDR_W-1:COL_W];
                        wt_q <= RAH_CYC - 8'h01;
                        state_q <= ST_ROW;
                    end
                end
                ST_ROW: begin
                    if (wt_q == 8'h00) begin
                        pins_q.addr <= ROW_W'(cur_q.addr[COL_W-1:0]);
                        pins_q.we_n <= !cur_wr;
                        dq_oe_q <= cur_wr;
                        dq_out_q <= cur_q.wdata;
                        wt_q <= COL_WT;
                        state_q <= ST_COL;
                    end
                end
                ST_COL: begin
                    if (wt_q == 8'h00) begin
                        pins_q.low_byte_column_strobe_n <= !cur_q.be[0];
                        pins_q.high_byte_column_strobe_n <= !cur_q.be[1];
                        pins_q.oe_n <= cur_wr;
                        state_q <= ST_ACC;
                    end
                end
                ST_ACC: begin
                    if (cur_wr ? (pc_q >= RWL_CYC && rl_q >= RL_W'(RAS_MIN_CYC))
                               : (pc_q >= RD_CAS_CYC && rl_q >= RL_W'(RD_RAS_CYC))) begin
                        if (!cur_wr) begin
                            rsp_valid_q <= 1'b1;
                            rsp_data_q <= dq_s;
                        end
                        if (cur_q.rmw) begin
                            pins_q.oe_n <= 1'b1;
                            wt_q <= OED_CYC - 8'h01;
                            state_q <= ST_TURN;
                        end else begin
                            fin = 1'b1;
                        end
                    end
                end
                ST_TURN: begin
                    if (wt_q == 8'h00 && pc_q >= WE_CAS_CYC && rl_q >= RL_W'(RWD_CYC)) begin
                        pins_q.we_n <= 1'b0;
                        dq_oe_q <= 1'b1;
                        dq_out_q <= cur_q.wdata;
                        wt_q <= RWL_CYC - 8'h01;
                        state_q <= ST_WR;
                    end
                end
                ST_WR: begin
                    if (wt_q == 8'h00) fin = 1'b1;
                end
                ST_PAGE: begin
                    if (wt_q == 8'h00 && pc_q >= ((cur_q.rmw || req.rmw) ? PRC_CYC : PC_CYC)) begin
                        if (page_ok) begin
                            cur_q <= req;
                            ack_q <= 1'b1;
                            pins_q.addr <= ROW_W'(req.addr[COL_W-1:0]);
                            pins_q.we_n <= !(req.write && !req.rmw);
                            dq_oe_q <= req.write && !req.rmw;
                            dq_out_q <= req.wdata;
                            wt_q <= COL_WT;
                            state_q <= ST_COL;
                        end else begin
                            pins_q.ras_n <= 1'b1;
                            wt_q <= RP_CYC - 8'h01;
                            state_q <= ST_PRE;
                        end
                    end
                end
                ST_PRE: begin
                    if (wt_q == 8'h00) state_q <= ST_IDLE;
                end
                ST_RCAS, ST_HID: begin
                    if (wt_q == 8'h00) begin
                        pins_q.ras_n <= 1'b0;
                        wt_q <= REF_LOW_CYC - 8'h01;
                        state_q <= ST_RRAS;
                    end
                end
                ST_RRAS: begin
                    if (wt_q == 8'h00) begin
                        if (sr_mode_q) begin
                            sr_active_q <= 1'b1;
                            state_q <= ST_SR;
                        end else begin
                            pins_q <= PINS_IDLE;
                            wt_q <= RP_CYC - 8'h01;
                            state_q <= ST_PRE;
                        end
                    end
                end
                ST_SR: begin
                    if (!sr_req && rl_q >= RL_W'(SR_CYC)) begin
                        pins_q <= PINS_IDLE;
                        sr_mode_q <= 1'b0;
                        sr_active_q <= 1'b0;
                        wt_q <= RPS_CYC - 8'h01;
                        state_q <= ST_PRE;
                    end
                end
                default: begin
                    pins_q <= PINS_IDLE;
                    state_q <= ST_PRE;
                end
            endcase
            if (fin) begin
                pins_q.we_n <= 1'b1;
                dq_oe_q <= 1'b0;
                if (ref_pend_q && !cur_q.write && !cur_q.rmw) begin
                    pins_q.ras_n <= 1'b1;
                    ref_pend_q <= ref_tick;
                    wt_q <= RP_CYC - 8'h01;
                    state_q <= ST_HID;
                end else begin
                    pins_q.low_byte_column_strobe_n <= 1'b1;
                    pins_q.high_byte_column_strobe_n <= 1'b1;
                    pins_q.oe_n <= 1'b1;
                    if (page_ok) begin
                        wt_q <= CP_CYC - 8'h01;
                        state_q <= ST_PAGE;
                    end else begin
                        pins_q.ras_n <= 1'b1;
                        wt_q <= RP_CYC - 8'h01;
                        state_q <= ST_PRE;
                    end
                end
            end
        end
    end

    assign pins = pins_q;
    assign req_ack = ack_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_data = rsp_data_q;
    assign sr_active = sr_active_q;
    assign init_done = init_done_q;
    assign dq_out = dq_out_q;
    assign dq_oe = dq_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // checking helpers: high time of the row strobe, refreshes seen
    logic [7:0] rh_q;
    logic [3:0] refs_q;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rh_q <= '0;
            refs_q <= '0;
        end else begin
            rh_q <= !pins_q.ras_n ? '0 : ((&rh_q) ? rh_q : rh_q + 8'h01);
            if (state_q == ST_RCAS && wt_q == 8'h00 && !(&refs_q)) refs_q <= refs_q + 4'h1;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_row_precharge: assert property ($fell(pins_q.ras_n) |-> rh_q >= RP_CYC)
        else $error("row strobe precharge too short");
    a_early_write: assert property (
        $fell(cas_n) && state_q == ST_ACC && cur_wr |-> !pins_q.we_n && dq_oe_q)
        else $error("early write without write enable set up");
    a_rmw_we_delay: assert property (
        $fell(pins_q.we_n) && cur_q.rmw |-> rl_q >= RL_W'(RWD_CYC) && pc_q >= WE_CAS_CYC)
        else $error("read-modify-write enable too early");
    a_read_we_high: assert property (
        state_q == ST_ACC && !cur_q.write && !cur_q.rmw |-> pins_q.we_n ##1 pins_q.we_n)
        else $error("write enable fell during read");
    a_page_max: assert property (!pins_q.ras_n && state_q != ST_SR |-> rl_q < RL_W'(RASP_CYC))
        else $error("row strobe low beyond page maximum");
    a_page_gap: assert property (
        state_q == ST_COL && $past(state_q) == ST_PAGE |-> pc_q >= PC_CYC)
        else $error("page accesses too close");
    a_refresh_order: assert property (
        $fell(pins_q.ras_n) && !cas_n && state_q == ST_RRAS |->
            $past(!cas_n, 2) ##1 !cas_n ##1 !cas_n)
        else $error("strobe-order refresh setup or hold broken");
    a_init_refs: assert property ($rose(init_done_q) |-> refs_q >= 4'(INIT_REFS))
        else $error("normal use before eight refresh cycles");
    a_sr_hold: assert property (
        state_q == ST_PRE && $past(state_q) == ST_SR |-> $past(rl_q) >= RL_W'(SR_CYC))
        else $error("self-refresh left too early");
    a_sr_exit: assert property (
        state_q == ST_PRE && $past(state_q) == ST_SR |-> pins_q.ras_n[*8])
        else $error("row strobe fell too soon after self-refresh");
    a_hidden_cas: assert property (state_q == ST_HID |-> !cas_n && pins_q.ras_n)
        else $error("hidden refresh lost column strobe");

    c_page: cover property (state_q == ST_PAGE ##1 state_q == ST_COL);
    c_rmw: cover property (state_q == ST_TURN ##[1:20] state_q == ST_WR);
    c_self_ref: cover property (state_q == ST_SR ##1 state_q == ST_PRE);
    c_hidden: cover property (state_q == ST_HID);
endmodule // adct_ctrl
`default_nettype wire

// ### tb/adct_dram_model.sv
`timescale 1ns/1ps
`default_nettype none
module adct_dram_model
    import adct_pkg::*;
(
    input wire logic sys_clk,
    input wire adct_pins_s pins,
    input wire logic [DATA_W-1:0] dq_out,
    input wire logic dq_oe,
    output logic [DATA_W-1:0] dq_in
);
    logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
    adct_pins_s prev_q = PINS_IDLE;
    logic [ROW_W-1:0] row_q = 12'h000;
    logic [COL_W-1:0] col_q = 8'h00;
    logic [DATA_W-1:0] last_q = 16'h0000;
    int unsigned refresh_row_q = 0;
    logic cas_low;
    logic cas_was_low;
    assign cas_low = !(pins.high_byte_column_strobe_n && pins.low_byte_column_strobe_n);
    assign cas_was_low = !(prev_q.high_byte_column_strobe_n && prev_q.low_byte_column_strobe_n);
    task automatic store(input logic [COL_W-1:0] col);
        logic [DATA_W-1:0] w;
        w = mem.exists({row_q, col}) ? mem[{row_q, col}] : 16'h0000;
        if (!pins.low_byte_column_strobe_n) w[7:0] = dq_out[7:0];
        if (!pins.high_byte_column_strobe_n) w[15:8] = dq_out[15:8];
        mem[{row_q, col}] = w;
    endtask
    always @(posedge sys_clk) begin
        if (prev_q.ras_n && !pins.ras_n && cas_low) begin
            refresh_row_q <= refresh_row_q + 1;
        end else if (prev_q.ras_n && !pins.ras_n) begin
            row_q <= pins.addr;
        end
        if (!pins.ras_n && !cas_was_low && cas_low) begin
            col_q <= pins.addr[COL_W-1:0];
            if (!pins.we_n) store(pins.addr[COL_W-1:0]);
        end
        if (prev_q.we_n && !pins.we_n && cas_was_low && cas_low) store(col_q);
        last_q <= dq_in;
        prev_q <= pins;
    end
    // released bus shows a changing pattern, never the last value
    always @* begin
        if (!pins.oe_n && pins.we_n && cas_low && !dq_oe) begin
            dq_in = mem.exists({row_q, col_q}) ? mem[{row_q, col_q}] : 16'h0000;
        end else begin
            dq_in = ~last_q;
        end
    end
endmodule // adct_dram_model
`default_nettype wire

// ### tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import adct_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic sr_req = 1'b0;
    adct_req_s req = '0;
    logic req_ack, rsp_valid, sr_active, init_done, dq_oe;
    logic [DATA_W-1:0] rsp_data, dq_out, dq_in;
    adct_pins_s pins;
    int mismatches = 0;
    int num_checks = 0;
    int lo = 0;
    int hi = 0;
    int n;
    logic sr_seen = 1'b0;
    logic after_sr = 1'b0;
    logic [DATA_W-1:0] exp_q[$];
    logic [DATA_W-1:0] ref_mem [logic [ADDR_W-1:0]];
    logic [ADDR_W-1:0] addrs [12];
    logic [16:0] seed = 17'd76619;
    adct_ctrl #(.PWR_CYC(20), .SR_CYC(16), .RASP_CYC(200), .REFI_CYC(100)) adct_ctrl_inst (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req), .req_ack(req_ack),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .sr_req(sr_req), .sr_active(sr_active),
        .init_done(init_done), .pins(pins), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    adct_dram_model adct_dram_model_inst (.sys_clk(sys_clk), .pins(pins), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in));
    initial begin
        forever #4 sys_clk = ~sys_clk;
    end
    function automatic logic [16:0] lfsr(input logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        $display("mismatches=%0d num_checks=%0d", mismatches, num_checks);
        if (mismatches == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // called at a falling edge; request stays up until the acknowledge is seen
    task automatic issue(input logic w, input logic m, input logic [1:0] be,
        input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int k;
        req_valid = 1'b1;
        req = '{w, m, be, a, d};
        if (!w || m) exp_q.push_back(ref_mem[a]);
        if (w || m) ref_mem[a] = {be[1] ? d[15:8] : ref_mem[a][15:8], be[0] ? d[7:0] : ref_mem[a][7:0]};
        k = 0;
        do begin
            @(negedge sys_clk);
            k++;
        end while (req_ack !== 1'b1 && k < 3000);
        if (k >= 3000) begin
            mismatches++;
            end_of_test();
        end
    endtask
    always @(negedge sys_clk) begin
        if (rsp_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(rsp_data, 32'hFFFF_FFFF);
            else chk(rsp_data, exp_q.pop_front());
        end
    end
    always @(negedge sys_clk) begin
        if (rst) begin
            lo = 0;
            hi = 0;
        end else if (pins.ras_n) begin
            if (lo > 0) begin
                chk(lo <= 200, 1);
                if (sr_seen) chk(lo >= 16, 1);
                after_sr = sr_seen;
                sr_seen = 1'b0;
            end
            hi++;
            lo = 0;
        end else begin
            if (hi > 0) chk(hi >= (after_sr ? 14 : 7), 1);
            if (sr_active === 1'b1) sr_seen = 1'b1;
            lo++;
            hi = 0;
        end
    end
    initial begin
        #200000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        for (n = 0; n < 3000 && init_done !== 1'b1; n++) @(negedge sys_clk);
        chk(init_done, 1);
        chk(adct_dram_model_inst.refresh_row_q >= 8, 1);
        issue(1'b1, 1'b0, 2'b11, 20'h12345, 16'hA5C3);
        issue(1'b0, 1'b0, 2'b11, 20'h12345, 16'h0000);
        issue(1'b1, 1'b0, 2'b01, 20'h12345, 16'h1234);
        issue(1'b1, 1'b0, 2'b10, 20'h12345, 16'h5678);
        issue(1'b0, 1'b1, 2'b11, 20'h12345, 16'h0F0F);
        issue(1'b0, 1'b0, 2'b11, 20'h12345, 16'h0000);
        for (n = 0; n < 4; n++) issue(1'b1, 1'b0, 2'b11, {12'hABC, 8'(n)}, 16'(n * 7919));
        for (n = 0; n < 4; n++) issue(1'b0, 1'b0, 2'b11, {12'hABC, 8'(n)}, 16'h0000);
        for (n = 0; n < 12; n++) begin
            seed = lfsr(seed);
            addrs[n] = {seed[16:5], 8'(seed)};
            issue(1'b1, 1'b0, 2'b11, addrs[n], {seed[15:0]});
        end
        for (n = 0; n < 12; n++) issue(1'b0, n[0], 2'b11, addrs[n], 16'(~n));
        req_valid = 1'b0;
        sr_req = 1'b1;
        for (n = 0; n < 300 && sr_active !== 1'b1; n++) @(negedge sys_clk);
        chk(sr_active, 1);
        repeat (40) @(negedge sys_clk);
        sr_req = 1'b0;
        for (n = 0; n < 300 && sr_active !== 1'b0; n++) @(negedge sys_clk);
        chk(sr_active, 0);
        issue(1'b0, 1'b0, 2'b11, 20'h12345, 16'h0000);
        req_valid = 1'b0;
        for (n = 0; n < 500 && exp_q.size() > 0; n++) @(negedge sys_clk);
        chk(exp_q.size(), 0);
        end_of_test();
    end
endmodule // testbench
`default_nettype wire
